// ### sspl_pkg.sv
package sspl_pkg;
   localparam real CLK_MHZ = 50.0;
   localparam real FLASH_WAIT_MS = 4.5;
   localparam real EEPROM_WAIT_MS = 9.0;
   localparam real ERASE_WAIT_MS = 9.0;
   localparam real POWERUP_WAIT_MS = 20.0;

   function automatic int ms_to_cycles(real ms);
      return int'($ceil(ms * CLK_MHZ * 1000.0));
   endfunction : ms_to_cycles

   localparam int FLASH_WAIT_CYCLES = ms_to_cycles(FLASH_WAIT_MS);
   localparam int EEPROM_WAIT_CYCLES = ms_to_cycles(EEPROM_WAIT_MS);
   localparam int ERASE_WAIT_CYCLES = ms_to_cycles(ERASE_WAIT_MS);
   localparam int POWERUP_WAIT_CYCLES = ms_to_cycles(POWERUP_WAIT_MS);
   localparam int SCK_HALF_CYCLES = 4;
   localparam int SCK_MIN_LEVEL_CYCLES = 3;
   localparam int RESET_PULSE_CYCLES = 2;

   localparam int FLASH_ADDR_BITS = 13;
   localparam int PAGE_WORD_BITS = 6;
   localparam int PAGE_NUM_BITS = 7;
   localparam int EEPROM_ADDR_BITS = 9;
   localparam int HIGH_SEL_BIT = 3;

   localparam logic [7:0] OP_UNLOCK = 8'hac;
   localparam logic [7:0] UNLOCK_KEY = 8'h53;
   localparam logic [2:0] ERASE_KEY = 3'h4;
   localparam logic [7:0] OP_READ_FLASH = 8'h20;
   localparam logic [7:0] OP_LOAD_PAGE = 8'h40;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
   localparam logic [7:0] OP_READ_EEPROM = 8'ha0;
   localparam logic [7:0] OP_WRITE_EEPROM = 8'hc0;
   localparam logic [7:0] HIGH_SEL_MASK = 8'hf7;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage : sspl_pkg

// ### sspl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sspl_if;
   logic sck;
   logic mosi;
   logic miso;
   logic reset_n;
   modport dev (input sck, input mosi, input reset_n, output miso);
   modport host (output sck, output mosi, output reset_n, input miso);
endinterface : sspl_if
`default_nettype wire

// ### sspl_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sspl_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clock_in, // system clock
   input wire logic reset_in, // sync reset, high
   input wire logic [WIDTH-1:0] in_data_in, // write word
   input wire logic in_valid_in, // write request
   output logic in_ready_out, // room for a word
   output logic [WIDTH-1:0] out_data_out, // head word
   output logic out_valid_out, // head word present
   input wire logic out_ready_in // head taken
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   assign out_data_out = mem[rd_ptr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clock_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= next_count;
         in_ready_out <= next_count != (AW+1)'(DEPTH);
         out_valid_out <= next_count != '0;
      end
   end
endmodule : sspl_fifo
`default_nettype wire

// ### sspl_device.sv
// Overview of operation
// - programming accepted only while reset held low
// - unlock required before program or erase
// - chip erase sets both arrays to ones
// - programmer keeps SCK levels over three cycles
// - MOSI sampled at SCK rising edge
// - MISO changes at SCK falling edge
// - programmer holds reset high, SCK low at start
// - programmer waits 20 ms before unlock
// - second unlock byte echoed during third
// - programmer shifts four bytes, resyncs on bad echo
// - page buffer loaded by six-bit word index
// - programmer loads low byte before high
// - page write commits seven-bit page number
// - programmer waits page time without polling
// - EEPROM written bytewise with auto-erase
// - read returns addressed location on MISO
// - reset high leaves programming mode
// - page under write reads ones until done
// - all-ones page needs timed wait, not polling
// - waits 4.5 ms page, 9.0 ms EEPROM/erase
// - unlock opcode bytes ac then 53
// - load opcode 0100H000, commit 0100 1100
// - EEPROM read a0, write c0 opcodes
`timescale 1ns/10ps
`default_nettype none
module sspl_device #(
   parameter int FLASH_BUSY_CYCLES = sspl_pkg::FLASH_WAIT_CYCLES,
   parameter int EEPROM_BUSY_CYCLES = sspl_pkg::EEPROM_WAIT_CYCLES,
   parameter int ERASE_BUSY_CYCLES = sspl_pkg::ERASE_WAIT_CYCLES
) (
   input wire logic CLOCK_IN, // system clock
   input wire logic RESET_IN, // sync reset, high
   sspl_if.dev LINK, // serial programming link
   output logic PROG_MODE_OUT, // programming mode active
   output logic UNLOCKED_OUT, // unlock accepted
   output logic BUSY_OUT // self-timed write running
);
   localparam int FW = sspl_pkg::FLASH_ADDR_BITS;
   localparam int EW = sspl_pkg::EEPROM_ADDR_BITS;
   localparam int PW = sspl_pkg::PAGE_WORD_BITS;
   localparam int PN = sspl_pkg::PAGE_NUM_BITS;

   if (ERASE_BUSY_CYCLES <= (1 << FW) || FLASH_BUSY_CYCLES <= (1 << PW) || EEPROM_BUSY_CYCLES < 1)
   begin : g_bad_timing
      $error("busy times too short for the erase and page sweeps");
   end

   typedef enum {SSPL_IDLE, SSPL_PAGE, SSPL_EEP, SSPL_ERASE} sspl_op_type;

   logic [15:0] flash [1 << FW];
   logic [7:0] eeprom [1 << EW];
   logic [15:0] page_buf [1 << PW];

   logic [1:0] sck_sync;
   logic [1:0] mosi_sync;
   logic [1:0] rstn_sync;
   logic sck_prev;
   logic rise;
   logic fall;
   logic prog;
   logic [2:0] bit_cnt;
   logic [1:0] byte_idx;
   logic [7:0] rx_shift;
   logic [7:0] new_byte;
   logic byte_end;
   logic [7:0] cmd;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] tx_shift;
   logic [7:0] next_tx;
   logic [7:0] read_byte;
   logic miso;
   logic unlocked;
   logic exec;
   sspl_op_type op;
   logic [31:0] busy_cnt;
   logic [31:0] busy_limit;
   logic [FW:0] sweep;
   logic [PN-1:0] page_num;
   logic [EW-1:0] eep_addr;
   logic [7:0] eep_data;
   logic [FW-1:0] rd_word;
   logic [EW-1:0] rd_eep;

   // link pins cross into the system clock
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         sck_sync <= 2'h0;
         mosi_sync <= 2'h0;
         rstn_sync <= 2'h3;
         sck_prev <= 1'b0;
      end else begin
         sck_sync <= {sck_sync[0], LINK.sck};
         mosi_sync <= {mosi_sync[0], LINK.mosi};
         rstn_sync <= {rstn_sync[0], LINK.reset_n};
         sck_prev <= sck_sync[1];
      end
   end

   assign prog = ~rstn_sync[1];
   assign rise = sck_sync[1] & ~sck_prev;
   assign fall = ~sck_sync[1] & sck_prev;
   assign byte_end = prog & rise & (bit_cnt == 3'h7);
   assign new_byte = {rx_shift[6:0], mosi_sync[1]};
   assign exec = byte_end & (byte_idx == 2'h3);
   assign rd_word = {b2[4:0], new_byte};
   assign rd_eep = {b2[0], new_byte};

   // data returned in the fourth byte
   always_comb begin
      read_byte = 8'h00;
      if ((cmd & sspl_pkg::HIGH_SEL_MASK) == sspl_pkg::OP_READ_FLASH) begin
         if (op == SSPL_ERASE || (op == SSPL_PAGE && rd_word[FW-1:PW] == page_num)) begin
            read_byte = sspl_pkg::ERASED_BYTE;
         end else if (cmd[sspl_pkg::HIGH_SEL_BIT]) begin
            read_byte = flash[rd_word][15:8];
         end else begin
            read_byte = flash[rd_word][7:0];
         end
      end else if (cmd == sspl_pkg::OP_READ_EEPROM) begin
         if (op == SSPL_ERASE || (op == SSPL_EEP && rd_eep == eep_addr)) begin
            read_byte = sspl_pkg::ERASED_BYTE;
         end else begin
            read_byte = eeprom[rd_eep];
         end
      end
   end

   // previous byte echoes; fourth byte carries read data
   always_comb begin
      case (byte_idx)
         2'h0: next_tx = new_byte;
         2'h1: next_tx = new_byte;
         2'h2: next_tx = read_byte;
         default: next_tx = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || !prog) begin
         bit_cnt <= 3'h0;
         byte_idx <= 2'h0;
         rx_shift <= 8'h00;
         cmd <= 8'h00;
         b2 <= 8'h00;
         b3 <= 8'h00;
      end else if (rise) begin
         rx_shift <= new_byte;
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            byte_idx <= byte_idx + 2'h1;
            if (byte_idx == 2'h0) begin
               cmd <= new_byte;
            end
            if (byte_idx == 2'h1) begin
               b2 <= new_byte;
            end
            if (byte_idx == 2'h2) begin
               b3 <= new_byte;
            end
         end
      end
   end

   // a loaded byte leaves MSB first over the next eight falls
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || !prog) begin
         tx_shift <= 8'h00;
         miso <= 1'b0;
      end else if (byte_end) begin
         tx_shift <= next_tx;
      end else if (fall) begin
         miso <= tx_shift[7];
         tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || !prog) begin
         unlocked <= 1'b0;
      end else if (exec && cmd == sspl_pkg::OP_UNLOCK && b2 == sspl_pkg::UNLOCK_KEY) begin
         unlocked <= 1'b1;
      end
   end

   // self-timed write engine; keeps running if the session ends
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         op <= SSPL_IDLE;
         busy_cnt <= 32'h0;
         busy_limit <= 32'h0;
         sweep <= '0;
         page_num <= '0;
         eep_addr <= '0;
         eep_data <= 8'h00;
      end else if (op == SSPL_IDLE) begin
         busy_cnt <= 32'h0;
         sweep <= '0;
         if (exec && unlocked) begin
            if (cmd == sspl_pkg::OP_UNLOCK && b2[7:5] == sspl_pkg::ERASE_KEY) begin
               op <= SSPL_ERASE;
               busy_limit <= 32'(ERASE_BUSY_CYCLES - 1);
            end else if (cmd == sspl_pkg::OP_WRITE_PAGE) begin
               op <= SSPL_PAGE;
               page_num <= {b2[4:0], b3[7:6]};
               busy_limit <= 32'(FLASH_BUSY_CYCLES - 1);
            end else if (cmd == sspl_pkg::OP_WRITE_EEPROM) begin
               op <= SSPL_EEP;
               eep_addr <= {b2[0], b3};
               eep_data <= new_byte;
               busy_limit <= 32'(EEPROM_BUSY_CYCLES - 1);
            end
         end
      end else begin
         busy_cnt <= busy_cnt + 32'h1;
         if (!sweep[FW]) begin
            sweep <= sweep + (FW+1)'(1);
         end
         if (busy_cnt == busy_limit) begin
            op <= SSPL_IDLE;
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (exec && unlocked && op == SSPL_IDLE
          && (cmd & sspl_pkg::HIGH_SEL_MASK) == sspl_pkg::OP_LOAD_PAGE) begin
         if (cmd[sspl_pkg::HIGH_SEL_BIT]) begin
            page_buf[b3[PW-1:0]][15:8] <= new_byte;
         end else begin
            page_buf[b3[PW-1:0]][7:0] <= new_byte;
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (op == SSPL_ERASE && !sweep[FW]) begin
         flash[sweep[FW-1:0]] <= {2{sspl_pkg::ERASED_BYTE}};
         if (sweep < (FW+1)'(1 << EW)) begin
            eeprom[sweep[EW-1:0]] <= sspl_pkg::ERASED_BYTE;
         end
      end else if (op == SSPL_PAGE && sweep < (FW+1)'(1 << PW)) begin
         flash[{page_num, sweep[PW-1:0]}] <= page_buf[sweep[PW-1:0]];
      end else if (op == SSPL_EEP && busy_cnt == busy_limit) begin
         eeprom[eep_addr] <= eep_data;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         PROG_MODE_OUT <= 1'b0;
         UNLOCKED_OUT <= 1'b0;
         BUSY_OUT <= 1'b0;
      end else begin
         PROG_MODE_OUT <= prog;
         UNLOCKED_OUT <= unlocked;
         BUSY_OUT <= op != SSPL_IDLE;
      end
   end

   assign LINK.miso = miso;
endmodule : sspl_device
`default_nettype wire

// ### sspl_host.sv
`timescale 1ns/10ps
`default_nettype none
module sspl_host #(
   parameter int POWERUP_CYCLES = sspl_pkg::POWERUP_WAIT_CYCLES,
   parameter int FLASH_GAP_CYCLES = sspl_pkg::FLASH_WAIT_CYCLES,
   parameter int EEPROM_GAP_CYCLES = sspl_pkg::EEPROM_WAIT_CYCLES,
   parameter int ERASE_GAP_CYCLES = sspl_pkg::ERASE_WAIT_CYCLES,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLOCK_IN, // system clock
   input wire logic RESET_IN, // sync reset, high
   sspl_if.host LINK, // serial programming link
   input wire logic SESSION_IN, // hold a programming session
   input wire logic [31:0] CMD_DATA_IN, // instruction, byte 1 in [31:24]
   input wire logic CMD_VALID_IN, // instruction offered
   output logic CMD_READY_OUT, // instruction queue has room
   output logic [31:0] RESP_DATA_OUT, // bytes returned on MISO
   output logic RESP_VALID_OUT, // response pulse
   output logic SYNC_FAIL_OUT // unlock echo wrong pulse
);
   localparam int HALF = sspl_pkg::SCK_HALF_CYCLES;
   if (HALF <= sspl_pkg::SCK_MIN_LEVEL_CYCLES || POWERUP_CYCLES < 1) begin : g_bad_timing
      $error("serial clock levels must exceed three clock cycles");
   end

   typedef enum {SSPL_OFF, SSPL_PULSE, SSPL_WAIT, SSPL_READY, SSPL_SHIFT, SSPL_GAP} sspl_host_type;

   sspl_host_type state;
   logic [31:0] cnt;
   logic [31:0] gap;
   logic [1:0] miso_sync;
   logic [31:0] tx;
   logic [31:0] saved;
   logic [31:0] rx;
   logic [31:0] next_rx;
   logic [4:0] bit_idx;
   logic retry;
   logic sck;
   logic mosi;
   logic reset_n;
   logic [31:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;

   function automatic logic [31:0] gap_for(input logic [31:0] w);
      if (w[31:24] == sspl_pkg::OP_WRITE_PAGE) begin
         return 32'(FLASH_GAP_CYCLES);
      end else if (w[31:24] == sspl_pkg::OP_WRITE_EEPROM) begin
         return 32'(EEPROM_GAP_CYCLES);
      end else if (w[31:24] == sspl_pkg::OP_UNLOCK && w[23:21] == sspl_pkg::ERASE_KEY) begin
         return 32'(ERASE_GAP_CYCLES);
      end
      return 32'(HALF);
   endfunction : gap_for

   sspl_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) sspl_fifo_inst (
      .clock_in(CLOCK_IN),
      .reset_in(RESET_IN),
      .in_data_in(CMD_DATA_IN),
      .in_valid_in(CMD_VALID_IN),
      .in_ready_out(CMD_READY_OUT),
      .out_data_out(fifo_data),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_pop)
   );

   assign fifo_pop = state == SSPL_READY && SESSION_IN && !retry && fifo_valid;
   assign next_rx = {rx[30:0], miso_sync[1]};

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         miso_sync <= 2'h0;
      end else begin
         miso_sync <= {miso_sync[0], LINK.miso};
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         state <= SSPL_OFF;
         cnt <= 32'h0;
         gap <= 32'h0;
         tx <= 32'h0;
         saved <= 32'h0;
         rx <= 32'h0;
         bit_idx <= 5'h0;
         retry <= 1'b0;
         sck <= 1'b0;
         mosi <= 1'b0;
         reset_n <= 1'b1;
         RESP_DATA_OUT <= 32'h0;
         RESP_VALID_OUT <= 1'b0;
         SYNC_FAIL_OUT <= 1'b0;
      end else begin
         RESP_VALID_OUT <= 1'b0;
         SYNC_FAIL_OUT <= 1'b0;
         cnt <= cnt + 32'h1;
         case (state)
            SSPL_OFF: begin
               reset_n <= 1'b1;
               sck <= 1'b0;
               cnt <= 32'h0;
               if (SESSION_IN) begin
                  state <= SSPL_PULSE;
               end
            end
            SSPL_PULSE: begin
               if (cnt >= 32'(sspl_pkg::RESET_PULSE_CYCLES - 1)) begin
                  reset_n <= 1'b0;
                  cnt <= 32'h0;
                  state <= SSPL_WAIT;
               end
            end
            SSPL_WAIT: begin
               if (cnt == 32'(POWERUP_CYCLES - 1)) begin
                  state <= SSPL_READY;
               end
            end
            SSPL_READY: begin
               cnt <= 32'h0;
               bit_idx <= 5'h0;
               if (!SESSION_IN) begin
                  state <= SSPL_OFF;
               end else if (retry || fifo_valid) begin
                  tx <= retry ? saved : fifo_data;
                  saved <= retry ? saved : fifo_data;
                  mosi <= retry ? saved[31] : fifo_data[31];
                  retry <= 1'b0;
                  state <= SSPL_SHIFT;
               end
            end
            SSPL_SHIFT: begin
               if (cnt == 32'(HALF - 1)) begin
                  cnt <= 32'h0;
                  sck <= ~sck;
                  if (sck) begin
                     rx <= next_rx;
                     bit_idx <= bit_idx + 5'h1;
                     tx <= {tx[30:0], 1'b0};
                     mosi <= tx[30];
                     if (bit_idx == 5'h1f) begin
                        RESP_DATA_OUT <= next_rx;
                        RESP_VALID_OUT <= 1'b1;
                        if (saved[31:16] == {sspl_pkg::OP_UNLOCK, sspl_pkg::UNLOCK_KEY}
                            && next_rx[15:8] != sspl_pkg::UNLOCK_KEY) begin
                           retry <= 1'b1;
                           SYNC_FAIL_OUT <= 1'b1;
                           reset_n <= 1'b1;
                           state <= SSPL_PULSE;
                        end else begin
                           gap <= gap_for(saved);
                           state <= SSPL_GAP;
                        end
                     end
                  end
               end
            end
            SSPL_GAP: begin
               if (cnt >= gap - 32'h1) begin
                  state <= SSPL_READY;
               end
            end
            default: state <= SSPL_OFF;
         endcase
      end
   end

   assign LINK.sck = sck;
   assign LINK.mosi = mosi;
   assign LINK.reset_n = reset_n;
endmodule : sspl_host
`default_nettype wire

// ### sspl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sspl_asserts #(
   parameter int POWERUP_CYCLES = 50
) (
   input wire logic CLOCK_IN, // system clock
   input wire logic RESET_IN, // sync reset, high
   input wire logic sck, // serial clock
   input wire logic mosi, // host to device data
   input wire logic miso, // device to host data
   input wire logic reset_n // device reset, low active
);
   logic sck_q;
   logic rise;
   logic [4:0] bit_cnt;
   logic [3:0] low_cnt;
   logic [23:0] mosi_sr;
   logic [23:0] miso_sr;
   int wait_cnt;

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RESET_IN);

   assign rise = sck & ~sck_q;

   always_ff @(posedge CLOCK_IN) begin
      sck_q <= sck;
   end

   // bit position within the current four-byte frame
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || reset_n) begin
         bit_cnt <= 5'h0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 5'h1;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (rise) begin
         mosi_sr <= {mosi_sr[22:0], mosi};
         miso_sr <= {miso_sr[22:0], miso};
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || sck) begin
         low_cnt <= 4'h0;
      end else if (low_cnt != 4'hf) begin
         low_cnt <= low_cnt + 4'h1;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN || reset_n) begin
         wait_cnt <= 0;
      end else if (wait_cnt < POWERUP_CYCLES) begin
         wait_cnt <= wait_cnt + 1;
      end
   end

   sck_level_hold_a : assert property ($changed(sck) |=> $stable(sck) [*3])
      else $error("serial clock level too short");
   mosi_hold_high_a : assert property (rise |-> $stable(mosi) [*4])
      else $error("host data moved while clock high");
   miso_hold_high_a : assert property (rise |=> $stable(miso) [*3])
      else $error("device data moved while clock high");
   sck_startup_low_a : assert property ($fell(reset_n) |-> !sck [*8])
      else $error("serial clock not low after reset low");
   reset_pulse_len_a : assert property ($rose(reset_n) |-> reset_n [*2])
      else $error("reset pulse shorter than two cycles");
   powerup_wait_a : assert property (rise |-> wait_cnt >= POWERUP_CYCLES)
      else $error("clocking started before power-up wait");
   frame_whole_a : assert property (low_cnt == 4'h6 |-> bit_cnt == 5'h0)
      else $error("pause inside a four-byte frame");
   byte_echo_a : assert property (rise && bit_cnt == 5'd15 |=> miso_sr[7:0] == mosi_sr[15:8])
      else $error("second byte out differs from first byte in");
   unlock_echo_a : assert property (rise && bit_cnt == 5'd23 |=>
      mosi_sr[23:16] != sspl_pkg::OP_UNLOCK || mosi_sr[15:8] != sspl_pkg::UNLOCK_KEY
      || miso_sr[7:0] == sspl_pkg::UNLOCK_KEY)
      else $error("unlock key not echoed");
endmodule : sspl_asserts
`default_nettype wire

// ### test_spi_serial_program_loader.sv
`timescale 1ns/10ps
`default_nettype none
module test_spi_serial_program_loader;
   localparam int POWERUP = 50;
   localparam int NCMD = 19;
   localparam int ERASE_SIM = 9000;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic session_in = 1'b0;
   logic [31:0] cmd_data = 32'h0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [31:0] resp_data;
   logic resp_valid;
   logic sync_fail;
   logic prog_mode;
   logic unlocked;
   logic busy;
   logic [31:0] resp_q[$];
   int err_count = 0;
   int cmp_count = 0;
   int busy_seen = 0;
   int fail_seen = 0;
   // unlock, erase, reads, page load and commit, polling, eeprom writes, then a locked session
   logic [31:0] cmds [NCMD] = '{32'hac530000, 32'hac800000, 32'h20004500, 32'ha001ff00,
      32'h4000053c, 32'h480005a7, 32'h4c004000, 32'h20004500, 32'ha001ff00, 32'ha001ff00,
      32'h20004500, 32'h28004500, 32'h20000500, 32'hc001ff5a, 32'ha001ff00, 32'hc001ff81,
      32'ha001ff00, 32'hc0001033, 32'ha0001000};
   logic [31:0] msks [NCMD] = '{32'h0000ff00, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0,
      32'hff, 32'hff, 32'hff, 32'hff, 32'hff, 32'hff, 32'h0, 32'hff, 32'h0, 32'hff, 32'h0, 32'hff};
   logic [31:0] exps [NCMD] = '{32'h00005300, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0,
      32'hff, 32'hff, 32'hff, 32'h3c, 32'ha7, 32'hff, 32'h0, 32'h5a, 32'h0, 32'h81, 32'h0, 32'hff};

   sspl_if link_if();

   always #10 clock_in = ~clock_in;

   sspl_device #(
      .FLASH_BUSY_CYCLES(700),
      .EEPROM_BUSY_CYCLES(200),
      .ERASE_BUSY_CYCLES(ERASE_SIM)
   ) sspl_device_inst (
      .CLOCK_IN(clock_in),
      .RESET_IN(reset_in),
      .LINK(link_if.dev),
      .PROG_MODE_OUT(prog_mode),
      .UNLOCKED_OUT(unlocked),
      .BUSY_OUT(busy)
   );

   // page gap kept short on purpose so reads land inside the page write
   sspl_host #(
      .POWERUP_CYCLES(POWERUP),
      .FLASH_GAP_CYCLES(100),
      .EEPROM_GAP_CYCLES(300),
      .ERASE_GAP_CYCLES(ERASE_SIM + 100)
   ) sspl_host_inst (
      .CLOCK_IN(clock_in),
      .RESET_IN(reset_in),
      .LINK(link_if.host),
      .SESSION_IN(session_in),
      .CMD_DATA_IN(cmd_data),
      .CMD_VALID_IN(cmd_valid),
      .CMD_READY_OUT(cmd_ready),
      .RESP_DATA_OUT(resp_data),
      .RESP_VALID_OUT(resp_valid),
      .SYNC_FAIL_OUT(sync_fail)
   );

   sspl_asserts #(
      .POWERUP_CYCLES(POWERUP)
   ) sspl_asserts_inst (
      .CLOCK_IN(clock_in),
      .RESET_IN(reset_in),
      .sck(link_if.sck),
      .mosi(link_if.mosi),
      .miso(link_if.miso),
      .reset_n(link_if.reset_n)
   );

   always @(posedge clock_in) begin
      if (resp_valid === 1'b1) begin
         resp_q.push_back(resp_data);
      end
      if (busy === 1'b1) begin
         busy_seen++;
      end
      if (sync_fail === 1'b1) begin
         fail_seen++;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // held until the edge that sees room, then released one edge
   task automatic send(input logic [31:0] w);
      int n;
      n = 0;
      cmd_data <= w;
      cmd_valid <= 1'b1;
      do begin
         @(posedge clock_in);
         n++;
      end while (cmd_ready !== 1'b1 && n < 400000);
      cmd_valid <= 1'b0;
      @(posedge clock_in);
   endtask : send

   task automatic wait_resp(input int n);
      int k;
      k = 0;
      while (resp_q.size() < n && k < 90000) begin
         @(posedge clock_in);
         k++;
      end
   endtask : wait_resp

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20) @(posedge clock_in);
      reset_in <= 1'b0;
      @(posedge clock_in);
      for (int i = 0; i < 16; i++) begin
         send(cmds[i]);
      end
      check({31'h0, cmd_ready}, 32'h0);
      check({31'h0, prog_mode}, 32'h0);
      session_in <= 1'b1;
      send(cmds[16]);
      wait_resp(17);
      check({31'h0, prog_mode}, 32'h1);
      check({31'h0, unlocked}, 32'h1);
      check({31'h0, busy_seen != 0}, 32'h1);
      session_in <= 1'b0;
      repeat (16) @(posedge clock_in);
      check({31'h0, prog_mode}, 32'h0);
      check({31'h0, unlocked}, 32'h0);
      send(cmds[17]);
      send(cmds[18]);
      session_in <= 1'b1;
      wait_resp(NCMD);
      check({31'h0, unlocked}, 32'h0);
      for (int i = 0; i < NCMD; i++) begin
         if (msks[i] != 32'h0) begin
            check(resp_q[i] & msks[i], exps[i]);
         end
      end
      check(fail_seen, 32'h0);
      final_report();
   end

   // whole sequence needs about 15000 cycles; cut at 100000
   initial begin
      #2000000;
      err_count++;
      final_report();
   end
endmodule : test_spi_serial_program_loader
`default_nettype wire
